// ### rtl/tpg_pkg.sv
package tpg_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int CNT_W = 12;
	localparam int CMP_W = 13;

	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PCR = 8'h04;
	localparam logic [7:0] ADDR_REP = 8'h08;
	localparam logic [7:0] ADDR_CMP0 = 8'h0c;
	localparam logic [7:0] ADDR_PAT = 8'h1c;
	localparam logic [7:0] ADDR_STAT = 8'h20;
	localparam logic [7:0] CMP_STRIDE = 8'h04;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_CKE = 0;
	localparam int CTRL_ROUTE = 1;
	localparam int CTRL_COMP = 2;
	localparam int CTRL_CHOP = 3;
	localparam int CTRL_DBG = 5;
	localparam int PCR_DIV = 0;
	localparam int PCR_ALIGN = 3;
	localparam int PCR_BYTE = 4;
	localparam int PCR_OVF = 5;

	// ------------------------------------------------------------
	// reset values and answers
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] PCR_RST = 8'h00;
	localparam logic [7:0] REP_RST = 8'h00;
	localparam logic [5:0] PAT_RST = 6'h00;
	localparam logic [15:0] PER_RST = 16'h0fff;
	localparam logic [15:0] CMP_RST = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		DIR_UP = 2'h1,
		DIR_DOWN = 2'h2
	} tpg_dir_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} tpg_wr_s;

endpackage

// ### rtl/tpg_axil.sv
module tpg_axil import tpg_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic wr_fire,
	output tpg_wr_s wr,
	input wire logic wr_ok,
	output logic [ADDR_W-1:0] rd_addr,
	input wire logic rd_ok,
	input wire logic [31:0] rd_data
);

	typedef struct packed {
		logic aw_full;
		logic w_full;
		tpg_wr_s cmd;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tpg_axil_s;

	tpg_axil_s st;
	tpg_axil_s next_st;

	assign awready = st.awready;
	assign wready = st.wready;
	assign bvalid = st.bvalid;
	assign bresp = st.bresp;
	assign arready = st.arready;
	assign rvalid = st.rvalid;
	assign rdata = st.rdata;
	assign rresp = st.rresp;
	assign wr = st.cmd;
	assign wr_fire = st.aw_full && st.w_full && !st.bvalid;
	assign rd_addr = araddr;

	always_comb begin
		next_st = st;
		if (awvalid && st.awready) begin
			next_st.aw_full = 1'b1;
			next_st.cmd.addr = awaddr;
		end
		if (wvalid && st.wready) begin
			next_st.w_full = 1'b1;
			next_st.cmd.data = wdata;
			next_st.cmd.strb = wstrb;
		end
		// address and data may come in either order
		if (wr_fire) begin
			next_st.aw_full = 1'b0;
			next_st.w_full = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		if (st.bvalid && bready)
			next_st.bvalid = 1'b0;
		if (arvalid && st.arready) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = rd_data;
			next_st.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		if (st.rvalid && rready)
			next_st.rvalid = 1'b0;
		// one write and one read in flight at most
		next_st.awready = !next_st.aw_full && !next_st.bvalid;
		next_st.wready = !next_st.w_full && !next_st.bvalid;
		next_st.arready = !next_st.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			st <= '0;
		else
			st <= next_st;
	end

endmodule

// ### rtl/tpg_top.sv
module tpg_top import tpg_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic [2:0] pwm_to_channel_mgr,
	output logic pwm_to_input_stage,
	output logic [2:0] drive_high,
	output logic [2:0] drive_low,
	output logic chop_high,
	output logic chop_low,
	output logic update_irq,
	output logic update_dbg
);

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] pcr;
		logic [7:0] rep;
		logic [3:0][15:0] pre;
		logic [3:0] pend;
		logic [5:0] pat;
		logic [2:0] div;
		logic align;
		logic bmode;
		logic [CNT_W-1:0] per;
		logic [2:0][CMP_W-1:0] cmp;
		logic [7:0] rep_cnt;
		logic [2:0] pre_cnt;
		logic [CNT_W-1:0] cnt;
		tpg_dir_e dir;
		logic cke_d;
		logic [2:0] pwm;
		logic [2:0] to_cm;
		logic to_in;
		logic [2:0] hi;
		logic [2:0] lo;
		logic chop_hi;
		logic chop_lo;
		logic irq;
		logic dbg;
	} tpg_st_s;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] cmp_addr(input int i);
		cmp_addr = ADDR_CMP0 + 8'(i) * CMP_STRIDE;
	endfunction

	function automatic logic reg_ok(input logic [ADDR_W-1:0] a);
		reg_ok = (a == ADDR_CTRL) || (a == ADDR_PCR) || (a == ADDR_REP)
			|| (a == ADDR_PAT) || (a == ADDR_STAT);
		for (int i = 0; i < 4; i++)
			if (a == cmp_addr(i))
				reg_ok = 1'b1;
	endfunction

	// rounding can carry past 13 bits, so saturate
	function automatic logic [CMP_W-1:0] round13(input logic [15:0] v);
		logic [CMP_W:0] s;
		s = {1'b0, v[15:3]} + {13'h0, v[2]};
		round13 = s[CMP_W] ? 13'h1fff : s[CMP_W-1:0];
	endfunction

	function automatic logic [CMP_W-1:0] cmp_load(input logic [15:0] v,
			input logic bm, input logic ovf);
		if (!bm)
			cmp_load = round13(v);
		else if (ovf)
			cmp_load = 13'h1fff;
		else
			cmp_load = {5'h00, v[7:0]};
	endfunction

	tpg_st_s st;
	tpg_st_s next_st;
	logic wr_fire;
	tpg_wr_s wr;
	logic [ADDR_W-1:0] rd_addr;
	logic [31:0] rd_data;
	logic tick;
	logic ovf_evt;
	logic udf_evt;
	logic upd;
	logic [CMP_W-1:0] c13;
	logic [CMP_W-1:0] ext;

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	tpg_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wr_fire(wr_fire),
		.wr(wr),
		.wr_ok(reg_ok(wr.addr)),
		.rd_addr(rd_addr),
		.rd_ok(reg_ok(rd_addr)),
		.rd_data(rd_data)
	);

	always_comb begin
		rd_data = 32'h0000_0000;
		case (rd_addr)
			ADDR_CTRL: rd_data = {24'h00_0000, st.ctrl};
			ADDR_PCR: rd_data = {24'h00_0000, st.pcr};
			ADDR_REP: rd_data = {24'h00_0000, st.rep};
			ADDR_PAT: rd_data = {26'h0, st.pat};
			ADDR_STAT: rd_data = {8'h00, st.rep_cnt,
				st.dir == DIR_DOWN, 3'h0, st.cnt};
			default: begin
				for (int i = 0; i < 4; i++)
					if (rd_addr == cmp_addr(i))
						rd_data = {16'h0000, st.pre[i]};
			end
		endcase
	end

	// ------------------------------------------------------------
	// counter, preload transfer, phases
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		tick = 1'b0;
		ovf_evt = 1'b0;
		udf_evt = 1'b0;
		upd = 1'b0;
		next_st.cke_d = st.ctrl[CTRL_CKE];
		if (!st.ctrl[CTRL_CKE]) begin
			next_st.cnt = '0;
			next_st.dir = DIR_UP;
			next_st.pre_cnt = 3'h0;
		end else begin
			tick = st.pre_cnt == st.div;
			next_st.pre_cnt = tick ? 3'h0 : st.pre_cnt + 3'h1;
			if (tick) begin
				case (st.dir)
					DIR_UP: begin
						if (st.cnt >= st.per) begin
							ovf_evt = 1'b1;
							if (st.align) begin
								next_st.dir = DIR_DOWN;
								next_st.cnt = st.cnt - 12'h001;
							end else begin
								next_st.cnt = '0;
							end
						end else begin
							next_st.cnt = st.cnt + 12'h001;
						end
					end
					DIR_DOWN: begin
						if (st.cnt == '0) begin
							udf_evt = 1'b1;
							next_st.dir = DIR_UP;
							next_st.cnt = 12'h001;
						end else begin
							next_st.cnt = st.cnt - 12'h001;
						end
					end
					default: next_st.dir = DIR_UP;
				endcase
			end
			// edge mode only overflows, so one step per cycle
			if (ovf_evt || udf_evt) begin
				if (st.rep_cnt == 8'h00)
					upd = 1'b1;
				else
					next_st.rep_cnt = st.rep_cnt - 8'h01;
			end
			if (!st.cke_d)
				upd = 1'b1;
		end
		if (upd) begin
			next_st.rep_cnt = st.rep;
			next_st.div = st.pcr[PCR_DIV+:3];
			next_st.align = st.pcr[PCR_ALIGN];
			next_st.bmode = st.pcr[PCR_BYTE];
			if (!st.pend[0])
				next_st.per = st.pcr[PCR_BYTE] ? {4'h0, st.pre[0][7:0]}
					: st.pre[0][11:0];
			for (int i = 0; i < 3; i++)
				if (!st.pend[i+1])
					next_st.cmp[i] = cmp_load(st.pre[i+1],
						st.pcr[PCR_BYTE], st.pcr[PCR_OVF+i]);
			next_st.pcr[PCR_OVF+:3] = 3'h0;
		end
		// a write in the update cycle lands after the clear: set wins
		if (wr_fire) begin
			if (wr.strb[0]) begin
				case (wr.addr)
					ADDR_CTRL: next_st.ctrl = wr.data[7:0];
					ADDR_PCR: next_st.pcr = wr.data[7:0];
					ADDR_REP: next_st.rep = wr.data[7:0];
					ADDR_PAT: next_st.pat = wr.data[5:0];
					default: next_st.ctrl = next_st.ctrl;
				endcase
			end
			for (int i = 0; i < 4; i++) begin
				if (wr.addr == cmp_addr(i)) begin
					if (wr.strb[0])
						next_st.pre[i][7:0] = wr.data[7:0];
					if (wr.strb[1])
						next_st.pre[i][15:8] = wr.data[15:8];
					if (wr.strb[1])
						next_st.pend[i] = 1'b0;
					else if (wr.strb[0] && !st.pcr[PCR_BYTE])
						next_st.pend[i] = 1'b1;
				end
			end
		end
		c13 = {1'b0, next_st.cnt};
		ext = {1'b0, next_st.per};
		for (int i = 0; i < 3; i++) begin
			if (!st.ctrl[CTRL_CKE] || next_st.cmp[i] == '0)
				next_st.pwm[i] = 1'b0;
			else if (next_st.cmp[i] > ext)
				next_st.pwm[i] = 1'b1;
			else if (next_st.dir == DIR_DOWN)
				next_st.pwm[i] = c13 <= next_st.cmp[i];
			else
				next_st.pwm[i] = c13 < next_st.cmp[i];
		end
		if (st.ctrl[CTRL_ROUTE]) begin
			next_st.to_cm = next_st.pwm;
			next_st.to_in = 1'b0;
			next_st.hi = next_st.pwm;
			next_st.lo = ~next_st.pwm;
		end else begin
			next_st.to_cm = {2'h0, next_st.pwm[0]};
			next_st.to_in = next_st.pwm[0];
			next_st.hi = st.pat[2:0] & {3{next_st.pwm[0]}};
			if (st.ctrl[CTRL_COMP])
				next_st.lo = st.pat[2:0] & {3{~next_st.pwm[0]}};
			else
				next_st.lo = st.pat[5:3] & {3{next_st.pwm[0]}};
		end
		if (!st.ctrl[CTRL_CKE]) begin
			next_st.hi = 3'h0;
			next_st.lo = 3'h0;
		end
		next_st.chop_hi = st.ctrl[CTRL_CHOP+1];
		next_st.chop_lo = st.ctrl[CTRL_CHOP];
		next_st.irq = upd;
		next_st.dbg = upd && st.ctrl[CTRL_DBG];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.ctrl <= CTRL_RST;
			st.pcr <= PCR_RST;
			st.rep <= REP_RST;
			st.pat <= PAT_RST;
			st.pre <= {CMP_RST, CMP_RST, CMP_RST, PER_RST};
			st.per <= PER_RST[11:0];
			st.dir <= DIR_UP;
		end else begin
			st <= next_st;
		end
	end
	assign pwm_to_channel_mgr = st.to_cm;
	assign pwm_to_input_stage = st.to_in;
	assign drive_high = st.hi;
	assign drive_low = st.lo;
	assign chop_high = st.chop_hi;
	assign chop_low = st.chop_lo;
	assign update_irq = st.irq;
	assign update_dbg = st.dbg;
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_top_turn;
		tick && st.dir == DIR_UP && st.cnt >= st.per;
	endsequence
	sequence s_rep_hit;
		(ovf_evt || udf_evt) && st.rep_cnt == 8'h00;
	endsequence

	chk_stop_zero: assert property (!st.ctrl[CTRL_CKE] |=> st.cnt == '0)
		else $error("counter not held at zero while stopped");
	chk_edge_wrap: assert property (s_top_turn and !st.align
		|=> st.cnt == '0 && st.dir == DIR_UP)
		else $error("edge counter did not wrap to zero");
	chk_center_turn: assert property (s_top_turn and st.align
		|=> st.dir == DIR_DOWN && st.cnt == $past(st.cnt) - 12'h001)
		else $error("center counter did not turn down");
	chk_zero_low: assert property (st.cmp[0] == '0 |-> !st.pwm[0])
		else $error("zero duty phase not low");
	chk_full_high: assert property (st.ctrl[CTRL_CKE] && st.cke_d
		&& st.cmp[2] > {1'b0, st.per} |-> st.pwm[2])
		else $error("full duty phase not high");
	chk_rep_update: assert property (s_rep_hit |=> st.irq
		&& st.rep_cnt == $past(st.rep))
		else $error("update or reload missed");
	chk_rep_hold: assert property ((ovf_evt || udf_evt)
		&& st.rep_cnt != 8'h00 && st.cke_d |=> !st.irq)
		else $error("update before repetition ran out");
	chk_pend_hold: assert property (upd && st.pend[1]
		|=> st.cmp[0] == $past(st.cmp[0]))
		else $error("half-written compare transferred");
	chk_ovf_clear: assert property (upd && !wr_fire
		|=> st.pcr[PCR_OVF+:3] == 3'h0)
		else $error("full-duty bits not cleared");
	chk_route_one: assert property (!st.ctrl[CTRL_ROUTE]
		|=> st.to_cm[2:1] == 2'h0 && st.to_in == st.pwm[0])
		else $error("single phase routing leaked");
	chk_start_upd: assert property (st.ctrl[CTRL_CKE] && !st.cke_d
		|=> st.irq ##1 !st.irq)
		else $error("start did not raise one update");
endmodule

// ### bench/tpg_far_end.sv
// ------------------------------------------------------------
// far side: phase levels as a channel manager sees them
// ------------------------------------------------------------
module tpg_far_end import tpg_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [2:0] pwm,
	input wire logic upd,
	input wire logic dbg,
	output logic [15:0] len,
	output logic [2:0][15:0] hi,
	output logic [15:0] n_upd,
	output logic [15:0] n_dbg
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] run;
	logic [2:0][15:0] acc;
	// windows run from one update pulse to the next
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run <= 16'h0000;
			acc <= '0;
			len <= 16'h0000;
			hi <= '0;
			n_upd <= 16'h0000;
			n_dbg <= 16'h0000;
		end else begin
			run <= upd ? 16'h0001 : run + 16'h0001;
			for (int i = 0; i < 3; i++) begin
				acc[i] <= upd ? 16'(pwm[i]) : acc[i] + 16'(pwm[i]);
			end
			if (upd) begin
				len <= run;
				hi <= acc;
			end
			n_upd <= n_upd + 16'(upd);
			n_dbg <= n_dbg + 16'(dbg);
		end
	end
endmodule

// ### bench/testbench.sv
module testbench import tpg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [ADDR_W-1:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [2:0] pwm, dh, dl;
	logic pin, ch, cl, upd, dbg;
	logic [15:0] len, n_upd, n_dbg;
	logic [2:0][15:0] hi;
	int failures = 0;
	int compares = 0;
	int k;
	always #5 aclk = ~aclk;
	tpg_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready),
		.pwm_to_channel_mgr(pwm), .pwm_to_input_stage(pin),
		.drive_high(dh), .drive_low(dl), .chop_high(ch), .chop_low(cl),
		.update_irq(upd), .update_dbg(dbg));
	tpg_far_end u_far (.aclk(aclk), .aresetn(aresetn), .pwm(pwm),
		.upd(upd), .dbg(dbg), .len(len), .hi(hi), .n_upd(n_upd),
		.n_dbg(n_dbg));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic close_out();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s, input logic [1:0] er);
		logic ad;
		logic dd;
		ad = 1'b0;
		dd = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && dd)) begin
			@(posedge aclk);
			if (awready && awvalid) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && wvalid) begin
				dd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b0;
		chk(32'(bresp), 32'(er));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp,
			input logic [31:0] m, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'b0;
		chk(rdata & m, exp);
		chk(32'(rresp), 32'(er));
	endtask
	// first windows after a change are mixed, so callers skip them
	task automatic waitu(input int n);
		repeat (n) begin
			do @(posedge aclk); while (!upd);
		end
		@(posedge aclk);
	endtask
	task automatic meas(input int el, input int eu, input int ew);
		chk(32'(len), el);
		chk(32'(hi[0]), eu);
		chk(32'(hi[1]), 0);
		chk(32'(hi[2]), ew);
	endtask
	// one carrier period of driver levels against pattern 3'h5
	task automatic drv(input int eh, input int el);
		int nh;
		int nl;
		nh = 0;
		nl = 0;
		@(posedge aclk);
		repeat (10) begin
			@(posedge aclk);
			nh = nh + int'(dh == 3'h5);
			nl = nl + int'(dl == 3'h5);
		end
		chk(nh, eh);
		chk(nl, el);
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(ADDR_CTRL, 32'h0, 32'hff, RESP_OKAY);
		rd(ADDR_PCR, 32'h0, 32'hff, RESP_OKAY);
		rd(ADDR_CMP0, 32'h0fff, 32'hffff, RESP_OKAY);
		rd(ADDR_CMP0 + 8'h04, 32'h0, 32'hffff, RESP_OKAY);
		rd(ADDR_STAT, 32'h0, 32'hfff, RESP_OKAY);
		rd(8'h40, 32'h0, 32'hffffffff, RESP_SLVERR);
		wr(8'h40, 32'h1, 4'h1, RESP_SLVERR);
		// period never zero
		wr(ADDR_CMP0, 32'h0009, 4'h3, RESP_OKAY);
		wr(ADDR_CMP0 + 8'h04, 32'h0020, 4'h3, RESP_OKAY);
		wr(ADDR_CMP0 + 8'h0c, 32'h7ff8, 4'h3, RESP_OKAY);
		wr(ADDR_CTRL, 32'h23, 4'h1, RESP_OKAY);
		waitu(3);
		meas(10, 4, 10);
		chk(32'(n_dbg), 32'(n_upd));
		chk(32'(pin), 0);
		chk(32'(dh ^ dl), 32'h7);
		wr(ADDR_CMP0 + 8'h04, 32'h0024, 4'h3, RESP_OKAY);
		waitu(3);
		meas(10, 5, 10);
		rd(ADDR_CMP0 + 8'h04, 32'h0024, 32'hffff, RESP_OKAY);
		wr(ADDR_CMP0 + 8'h04, 32'h0030, 4'h1, RESP_OKAY);
		waitu(3);
		chk(32'(hi[0]), 5);
		wr(ADDR_CMP0 + 8'h04, 32'h0000, 4'h2, RESP_OKAY);
		waitu(3);
		chk(32'(hi[0]), 6);
		wr(ADDR_REP, 32'h2, 4'h1, RESP_OKAY);
		waitu(3);
		meas(30, 18, 30);
		wr(ADDR_REP, 32'h0, 4'h1, RESP_OKAY);
		wr(ADDR_PCR, 32'h01, 4'h1, RESP_OKAY);
		waitu(3);
		meas(20, 12, 20);
		wr(ADDR_REP, 32'h1, 4'h1, RESP_OKAY);
		wr(ADDR_PCR, 32'h08, 4'h1, RESP_OKAY);
		waitu(3);
		meas(18, 12, 18);
		wr(ADDR_REP, 32'h0, 4'h1, RESP_OKAY);
		wr(ADDR_PCR, 32'h10, 4'h1, RESP_OKAY);
		// byte mode already staged, so a low write alone is complete
		wr(ADDR_CMP0 + 8'h04, 32'h0004, 4'h1, RESP_OKAY);
		// leaving center mode may finish a turn counting down first
		waitu(4);
		meas(10, 4, 10);
		wr(ADDR_PCR, 32'h30, 4'h1, RESP_OKAY);
		waitu(2);
		meas(10, 10, 10);
		rd(ADDR_PCR, 32'h10, 32'hff, RESP_OKAY);
		wr(ADDR_CTRL, 32'h19, 4'h1, RESP_OKAY);
		waitu(2);
		chk(32'({ch, cl}), 32'h3);
		chk(32'(pwm[2:1]), 0);
		k = 0;
		repeat (10) begin
			@(posedge aclk);
			k = k + int'(pin);
		end
		chk(k, 4);
		wr(ADDR_PAT, 32'h05, 4'h1, RESP_OKAY);
		rd(ADDR_PAT, 32'h05, 32'hff, RESP_OKAY);
		drv(4, 0);
		wr(ADDR_CTRL, 32'h1d, 4'h1, RESP_OKAY);
		drv(4, 6);
		wr(ADDR_CTRL, 32'h00, 4'h1, RESP_OKAY);
		repeat (4) @(posedge aclk);
		rd(ADDR_STAT, 32'h0, 32'hfff, RESP_OKAY);
		chk(32'(pwm), 0);
		close_out();
	end
	// whole run is well under a thousand cycles; this is far beyond it
	initial begin
		#100us;
		failures++;
		close_out();
	end
endmodule
